//--- src/uhv_defs.svh
/*
  Constants for the serial-controller interrupt hand-off glue: restart opcode
  layout, direct service addresses, data space size and instruction cycles.
  Assumes it is included by its bare name from every file that needs it.
*/
`ifndef UHV_DEFS_SVH
`define UHV_DEFS_SVH

// Restart opcode is 11 nnn 111; nnn selects the restart slot
`define UHV_RST_OPC_BASE 8'hC7
`define UHV_RST_SLOT_LSB 3
`define UHV_RST_SLOT_W 3
// Restart address is slot times eight
`define UHV_RST_ADDR_SHIFT 3
// Direct service locations of the two external request inputs
`define UHV_EXT0_VECTOR 16'h0003
`define UHV_EXT1_VECTOR 16'h0013
// External data space above this size needs the high address port
`define UHV_SMALL_DATA_SPACE 256
// Cycles the host takes to finish its current instruction
`define UHV_INSTR_CYCLES 4'h4

`endif

//--- src/uhv_pkg.sv
/*
  Types used by the host end of the interrupt hand-off glue.
  Assumes uhv_defs.svh is on the include path.
*/
`default_nettype none

package uhv_pkg;
  // Host style: branch on a pin, or fetch a restart opcode on acknowledge
  typedef enum logic [1:0] {
    UHV_HOST_DIRECT = 2'h1,
    UHV_HOST_VECTORED = 2'h2
  } uhv_host_mode_e;

  // Host service sequencer states, one-hot
  typedef enum logic [4:0] {
    UHV_RUN = 5'h01,
    UHV_FINISH = 5'h02,
    UHV_ACK = 5'h04,
    UHV_SERVICE = 5'h08,
    UHV_RETURN = 5'h10
  } uhv_host_state_e;
endpackage

`default_nettype wire

//--- src/uhv_if.sv
/*
  Link between the serial controller end and the host processor end.
  Assumes one clock; the interface resolves the shared data bus from the
  enables carried here.
*/
`default_nettype none

interface uhv_if;
  logic uart_service_request_low;   // Controller request, active low
  logic acknowledge_strobe_low;     // Host acknowledge strobe, active low
  logic [7:0] vec_data_out;         // Opcode driven by the controller end
  logic vec_data_oe;                // High while the controller end drives data
  logic [7:0] low_addr_data_port;   // Multiplexed low address / data from host
  logic low_addr_data_oe;           // High while the host drives the low port
  logic [7:0] high_addr_port;       // Upper address byte from host
  logic addr_latch_strobe;          // High during the address half of a cycle
  logic mem_read_strobe_low;        // Host memory read strobe
  logic mem_write_strobe_low;       // Host memory write strobe
  logic port_read_strobe_low;       // Host port read strobe
  logic port_write_strobe_low;      // Host port write strobe
  logic request_acceptance_flag;    // Host is accepting requests

  // Data bus as both ends see it: controller wins only while enabled
  logic [7:0] data_bus;
  assign data_bus = vec_data_oe ? vec_data_out :
                    (low_addr_data_oe ? low_addr_data_port : 8'hFF);

  modport uart_end (
    output uart_service_request_low, vec_data_out, vec_data_oe,
    input acknowledge_strobe_low, low_addr_data_port, low_addr_data_oe,
    input high_addr_port, addr_latch_strobe, data_bus
  );
  modport host_end (
    input uart_service_request_low, data_bus,
    output acknowledge_strobe_low, low_addr_data_port, low_addr_data_oe,
    output high_addr_port, addr_latch_strobe, mem_read_strobe_low,
    output mem_write_strobe_low, port_read_strobe_low, port_write_strobe_low,
    output request_acceptance_flag
  );
endinterface

`default_nettype wire

//--- src/uhv_uart_end.sv
/*
  Controller end: raises the active-low service request from masked causes
  and answers the acknowledge strobe with a restart opcode on the data bus.
  Also demultiplexes the host low address byte on the address latch strobe.
  Assumes all inputs are synchronous to i_sys_clk.
*/
`include "uhv_defs.svh"
`default_nettype none

module uhv_uart_end #(
  parameter int CAUSE_W = 8,            // Number of request causes
  parameter logic [2:0] RST_SLOT = 3'h4 // Restart slot answered on acknowledge
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [CAUSE_W-1:0] i_cause_set,  // One-cycle cause events
  input wire logic [CAUSE_W-1:0] i_cause_clr,  // One-cycle clear by software
  input wire logic [CAUSE_W-1:0] i_cause_mask, // High enables a cause
  output logic [CAUSE_W-1:0] o_cause_pending,  // Sticky cause bits
  output logic [7:0] o_latched_addr_low,       // Demultiplexed low address
  output logic [15:0] o_bus_addr,              // Full latched address
  uhv_if.uart_end link
);
  logic [CAUSE_W-1:0] cause;        // Sticky causes
  logic [7:0] addr_low;             // Address byte captured from the low port
  logic req_low;                    // Registered request output
  logic next_req_low;

  // Sticky causes; a set in the same cycle as its clear wins
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause <= '0;
    end else begin
      cause <= (cause & ~i_cause_clr) | i_cause_set;
    end
  end
  assign o_cause_pending = cause;

  // Request is low while any enabled cause remains, high once all cleared
  always_comb begin
    next_req_low = ~|(cause & i_cause_mask);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_low <= 1'b1;
    end else begin
      req_low <= next_req_low;
    end
  end
  assign link.uart_service_request_low = req_low;

  // Transparent-latch behaviour made synchronous: follow the port while
  // the strobe is high, hold once it falls so data cannot corrupt it
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_low <= 8'h00;
    end else if (link.addr_latch_strobe && link.low_addr_data_oe) begin
      addr_low <= link.low_addr_data_port;
    end
  end
  assign o_latched_addr_low = addr_low;

  // Upper byte comes straight from the host high port, registered here
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_addr <= 16'h0000;
    end else begin
      o_bus_addr <= {link.high_addr_port, addr_low};
    end
  end

  // Opcode is a constant of the slot, so the data output stays stable
  assign link.vec_data_out = `UHV_RST_OPC_BASE | {2'h0, RST_SLOT, 3'h0};
  // Combinational enable so the bus is freed the same cycle either ends
  assign link.vec_data_oe = !req_low && !link.acknowledge_strobe_low;
endmodule

`default_nettype wire

//--- src/uhv_host_end.sv
/*
  Host end: a behavioural processor module that either branches directly
  on its external request input or runs an acknowledge cycle and fetches a
  restart opcode. Drives the multiplexed bus and control strobes.
  Assumes all inputs are synchronous to i_sys_clk.
*/
`include "uhv_defs.svh"
`default_nettype none

// Function
// - Hold request low while enabled cause pending
// - Release request once causes cleared, no acknowledge
// - Direct host branches without acknowledging
// - Request input 0 services at 0003H
// - Low port: address first, data second
// - High port carries upper address byte
// - Latch low address on address strobe
// - Acceptance flag high after enable instruction
// - Host finishes instruction before acknowledging
// - Host drives acknowledge low to start
// - Responder drives opcode during acknowledge
// - Vectored host takes restart address from bus byte
// - Opcodes C7..FF map to 0000..0038
// - Host loads matching restart address
// - Separate strobes for acknowledge, memory, port
// - Drive opcode only when request and acknowledge low
module uhv_host_end #(
  parameter logic [3:0] INSTR_CYCLES = `UHV_INSTR_CYCLES // Cycles per instruction
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire uhv_pkg::uhv_host_mode_e i_mode,  // Direct or vectored host
  input wire logic i_enable_instr,    // Software executes the enable instruction
  input wire logic i_disable_instr,   // Software disables requests
  input wire logic i_service_done,    // Service routine returns
  input wire logic i_mem_rd,          // Request a memory read cycle
  input wire logic i_mem_wr,          // Request a memory write cycle
  input wire logic i_port_rd,         // Request a port read cycle
  input wire logic i_port_wr,         // Request a port write cycle
  input wire logic [15:0] i_addr,     // Address of the bus cycle
  input wire logic [7:0] i_wdata,     // Write data
  output logic [15:0] o_pc,           // Program counter after vectoring
  output logic o_in_service,          // Executing a service routine
  output logic o_bad_vector,          // Last fetched byte was not a restart
  uhv_if.host_end link
);
  // Sequencer register and its decoded next value
  uhv_pkg::uhv_host_state_e state;
  uhv_pkg::uhv_host_state_e next_state;
  logic [3:0] instr_cnt;              // Cycles left in current instruction
  logic accept;                       // Acceptance flag
  logic [1:0] bus_phase;              // 0 idle, 1 address half, 2 data half
  logic rd_cyc;                       // Current bus cycle is a read

  // Restart address of a restart opcode: slot field times eight
  function automatic logic [15:0] rst_addr(input logic [7:0] opc);
    rst_addr = {10'h000, opc[`UHV_RST_SLOT_LSB +: `UHV_RST_SLOT_W], 3'h0};
  endfunction

  // True for the eight restart opcodes 11 nnn 111; an undriven bus reads FF,
  // the restart for slot seven, so a missing responder is not flagged
  function automatic logic is_restart(input logic [7:0] opc);
    is_restart = ((opc & 8'hC7) == `UHV_RST_OPC_BASE);
  endfunction

  // Enable instruction sets acceptance; taking a request clears it
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      accept <= 1'b0;
    end else if (state == uhv_pkg::UHV_FINISH && instr_cnt == 4'h0) begin
      // Taking a request wins over a same-cycle enable, so one request is
      // not taken twice before software enables again
      accept <= 1'b0;
    end else if (i_enable_instr) begin
      // Software has run the enable instruction
      accept <= 1'b1;
    end else if (i_disable_instr) begin
      accept <= 1'b0;
    end
  end
  assign link.request_acceptance_flag = accept;

  // Service sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      uhv_pkg::UHV_RUN:
        // A request counts only while acceptance is on
        if (accept && !link.uart_service_request_low) begin
          next_state = uhv_pkg::UHV_FINISH;
        end
      uhv_pkg::UHV_FINISH:
        // The current instruction always runs to its end first
        if (instr_cnt == 4'h0) begin
          next_state = (i_mode == uhv_pkg::UHV_HOST_VECTORED) ?
                       uhv_pkg::UHV_ACK : uhv_pkg::UHV_SERVICE;
        end
      // One acknowledge cycle fetches the vector byte
      uhv_pkg::UHV_ACK: next_state = uhv_pkg::UHV_SERVICE;
      uhv_pkg::UHV_SERVICE:
        // Stay in the routine until software returns
        if (i_service_done) begin
          next_state = uhv_pkg::UHV_RETURN;
        end
      // Return takes one cycle before requests are looked at again
      uhv_pkg::UHV_RETURN: next_state = uhv_pkg::UHV_RUN;
      // A corrupted one-hot code falls back to running
      default: next_state = uhv_pkg::UHV_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= uhv_pkg::UHV_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Instruction countdown reloaded in every running cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      instr_cnt <= 4'h0;
    end else if (state == uhv_pkg::UHV_RUN) begin
      // Kept full while running, so the count is ready when a request comes
      instr_cnt <= INSTR_CYCLES - 4'h1;
    end else if (instr_cnt != 4'h0) begin
      // Count down, then hold at zero
      instr_cnt <= instr_cnt - 4'h1;
    end
  end

  // Acknowledge low for one cycle; vector byte sampled in that cycle
  assign link.acknowledge_strobe_low = (state != uhv_pkg::UHV_ACK);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc <= 16'h0000;
      o_bad_vector <= 1'b0;
    end else if (state == uhv_pkg::UHV_ACK) begin
      // Vectored: the byte on the bus picks the restart address
      o_pc <= rst_addr(link.data_bus);
      o_bad_vector <= !is_restart(link.data_bus);
    end else if (state == uhv_pkg::UHV_FINISH && instr_cnt == 4'h0 &&
                 i_mode == uhv_pkg::UHV_HOST_DIRECT) begin
      // Direct: only request input 0 is modelled; input 1 would go to
      // its own fixed location instead
      o_pc <= `UHV_EXT0_VECTOR;
    end
  end
  assign o_in_service = (state == uhv_pkg::UHV_SERVICE);

  // Two-phase bus cycle: address half then data half
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_phase <= 2'h0;
      rd_cyc <= 1'b0;
    end else if (bus_phase == 2'h0 && (i_mem_rd || i_mem_wr || i_port_rd || i_port_wr)) begin
      // Start only when idle; a request in mid-cycle is dropped
      bus_phase <= 2'h1;
      rd_cyc <= i_mem_rd || i_port_rd;
    end else if (bus_phase == 2'h1) begin
      // Address half always moves on to the data half
      bus_phase <= 2'h2;
    end else begin
      // Data half ends the cycle
      bus_phase <= 2'h0;
    end
  end

  // Bus outputs registered; strobes registered per cycle kind
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.low_addr_data_port <= 8'h00;
      link.low_addr_data_oe <= 1'b0;
      link.high_addr_port <= 8'h00;
      link.addr_latch_strobe <= 1'b0;
      link.mem_read_strobe_low <= 1'b1;
      link.mem_write_strobe_low <= 1'b1;
      link.port_read_strobe_low <= 1'b1;
      link.port_write_strobe_low <= 1'b1;
    end else if (bus_phase == 2'h0 && (i_mem_rd || i_mem_wr || i_port_rd || i_port_wr)) begin
      // Address half: low port carries the low address byte
      link.low_addr_data_port <= i_addr[7:0];
      link.low_addr_data_oe <= 1'b1;
      link.high_addr_port <= i_addr[15:8];
      link.addr_latch_strobe <= 1'b1;
      link.mem_read_strobe_low <= !i_mem_rd;
      link.mem_write_strobe_low <= !i_mem_wr;
      link.port_read_strobe_low <= !i_port_rd;
      link.port_write_strobe_low <= !i_port_wr;
    end else if (bus_phase == 2'h1) begin
      // Data half: a read leaves the low port undriven for the responder
      link.low_addr_data_port <= i_wdata;
      link.low_addr_data_oe <= !rd_cyc;
      link.addr_latch_strobe <= 1'b0;
    end else begin
      // Idle or end of cycle: release the port and every strobe
      link.low_addr_data_oe <= 1'b0;
      link.addr_latch_strobe <= 1'b0;
      link.mem_read_strobe_low <= 1'b1;
      link.mem_write_strobe_low <= 1'b1;
      link.port_read_strobe_low <= 1'b1;
      link.port_write_strobe_low <= 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- testbench/uhv_link_monitor.sv
/*
  Checker on the link between the controller end and the host end.
  Assumes it sees the interface signals as plain inputs on one clock.
*/
`default_nettype none

module uhv_link_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic uart_service_request_low,
  input wire logic acknowledge_strobe_low,
  input wire logic [7:0] vec_data_out,
  input wire logic vec_data_oe,
  input wire logic low_addr_data_oe,
  input wire logic [7:0] high_addr_port,
  input wire logic addr_latch_strobe,
  input wire logic mem_read_strobe_low,
  input wire logic mem_write_strobe_low,
  input wire logic port_read_strobe_low,
  input wire logic port_write_strobe_low,
  input wire logic request_acceptance_flag,
  input wire logic [7:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ns;

  // All checks share the one clock and the link reset
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Bus strobes as one vector, active low
  logic [3:0] strobes;
  assign strobes = {mem_read_strobe_low, mem_write_strobe_low,
                    port_read_strobe_low, port_write_strobe_low};

  a_vec_gate_both: assert property (
    vec_data_oe == (!uart_service_request_low && !acknowledge_strobe_low))
    else $error("Vector driver enable does not follow request and acknowledge");
  a_ack_one_cycle: assert property (
    $fell(acknowledge_strobe_low) |=> acknowledge_strobe_low)
    else $error("Acknowledge strobe held low too long");
  // Request must have been pending five cycles back, with acceptance still on two cycles back
  a_ack_after_instr: assert property (
    $fell(acknowledge_strobe_low) |->
      $past(request_acceptance_flag, 2) && !$past(uart_service_request_low, 5))
    else $error("Acknowledge came before the instruction finished");
  a_opcode_restart: assert property (
    vec_data_oe |-> data_bus == vec_data_out && vec_data_out[7:6] == 2'h3
      && vec_data_out[2:0] == 3'h7)
    else $error("Vector byte on the bus is not a restart opcode");
  a_addr_then_data: assert property (
    $rose(addr_latch_strobe) |-> low_addr_data_oe ##1 !addr_latch_strobe
      ##1 (!low_addr_data_oe && strobes == 4'hF))
    else $error("Address and data halves out of order");
  a_high_addr_held: assert property (
    addr_latch_strobe |=> $stable(high_addr_port))
    else $error("Upper address byte changed within the cycle");
  a_one_strobe: assert property (
    $countones({~acknowledge_strobe_low, ~strobes}) <= 1)
    else $error("More than one control strobe low");
  a_strobe_two_cycles: assert property (
    $fell(&strobes) |-> addr_latch_strobe ##1 !(&strobes) ##1 (&strobes))
    else $error("Bus strobe width is wrong");
endmodule

`default_nettype wire

//--- testbench/tb.sv
/*
  Self-checking bench joining both ends through the link interface.
  Assumes the package, interface and both design ends are compiled first.
*/
`default_nettype none

`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [2:0] SLOT = 3'h5; // Not the default, so a hard-wired slot shows
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] cause_set = 8'h00;
  logic [7:0] cause_clr = 8'h00;
  logic [7:0] cause_mask = 8'h00;
  logic [2:0] ctl = 3'h0; // Software pulses: enable, disable, service done
  logic [3:0] cyc = 4'h0; // Bus cycle requests: mem rd, mem wr, port rd, port wr
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  uhv_pkg::uhv_host_mode_e mode = uhv_pkg::UHV_HOST_VECTORED;
  logic [7:0] pend, lat_low, vec_seen;
  logic [15:0] bus_addr, pc;
  logic in_svc, bad_vec;
  int fail_count = 0;
  int samples_checked = 0;
  int ack_count = 0;
  int seed = 80358;
  int model_pend = 0; // Behavioural copy of the sticky causes

  always #50 i_sys_clk = ~i_sys_clk;

  uhv_if link_if ();
  uhv_uart_end #(.CAUSE_W(8), .RST_SLOT(SLOT)) uhv_uart_end_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cause_set(cause_set),
    .i_cause_clr(cause_clr), .i_cause_mask(cause_mask), .o_cause_pending(pend),
    .o_latched_addr_low(lat_low), .o_bus_addr(bus_addr), .link(link_if.uart_end));
  uhv_host_end #(.INSTR_CYCLES(4'h4)) uhv_host_end_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mode(mode), .i_enable_instr(ctl[2]),
    .i_disable_instr(ctl[1]), .i_service_done(ctl[0]), .i_mem_rd(cyc[3]),
    .i_mem_wr(cyc[2]), .i_port_rd(cyc[1]), .i_port_wr(cyc[0]), .i_addr(addr),
    .i_wdata(wdata), .o_pc(pc), .o_in_service(in_svc), .o_bad_vector(bad_vec),
    .link(link_if.host_end));
  uhv_link_monitor uhv_link_monitor_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .uart_service_request_low(link_if.uart_service_request_low),
    .acknowledge_strobe_low(link_if.acknowledge_strobe_low),
    .vec_data_out(link_if.vec_data_out), .vec_data_oe(link_if.vec_data_oe),
    .low_addr_data_oe(link_if.low_addr_data_oe), .high_addr_port(link_if.high_addr_port),
    .addr_latch_strobe(link_if.addr_latch_strobe),
    .mem_read_strobe_low(link_if.mem_read_strobe_low),
    .mem_write_strobe_low(link_if.mem_write_strobe_low),
    .port_read_strobe_low(link_if.port_read_strobe_low),
    .port_write_strobe_low(link_if.port_write_strobe_low),
    .request_acceptance_flag(link_if.request_acceptance_flag), .data_bus(link_if.data_bus));

  // Count acknowledge cycles and keep the byte seen on the bus in them
  always @(negedge i_sys_clk) begin
    if (link_if.acknowledge_strobe_low === 1'b0) begin
      ack_count++;
      vec_seen = link_if.data_bus;
    end
  end

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic pulse(input logic [2:0] p);
    @(posedge i_sys_clk) ctl <= p;
    @(posedge i_sys_clk) ctl <= 3'h0;
  endtask

  // One set/clear pulse; request is two edges behind the pulse
  task automatic cause_op(input logic [7:0] s, input logic [7:0] c, input logic [7:0] m);
    @(posedge i_sys_clk);
    cause_set <= s;
    cause_clr <= c;
    cause_mask <= m;
    @(posedge i_sys_clk);
    cause_set <= 8'h00;
    cause_clr <= 8'h00;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    model_pend = (model_pend & ~int'(c)) | int'(s); // Set wins over clear
    `CHK(pend, model_pend[7:0])
    `CHK(link_if.uart_service_request_low, ((model_pend & int'(m)) == 0))
  endtask

  // One bus cycle of kind k, checked in its address and data halves
  task automatic bus_op(input logic [3:0] k);
    logic [15:0] a;
    logic [7:0] d;
    a = 16'($random(seed));
    d = 8'($random(seed));
    @(posedge i_sys_clk);
    cyc <= k;
    addr <= a;
    wdata <= d;
    @(posedge i_sys_clk) cyc <= 4'h0;
    @(negedge i_sys_clk);
    `CHK({link_if.mem_read_strobe_low, link_if.mem_write_strobe_low,
          link_if.port_read_strobe_low, link_if.port_write_strobe_low}, ~k)
    `CHK(link_if.data_bus, a[7:0])
    @(negedge i_sys_clk);
    `CHK(link_if.data_bus, ((k[3] | k[1]) ? 8'hFF : d))
    `CHK(lat_low, a[7:0])
    @(negedge i_sys_clk);
    `CHK(bus_addr, a)
  endtask

  // Bounded wait for the host to enter its service routine
  task automatic wait_svc;
    int n;
    n = 0;
    while (in_svc !== 1'b1 && n < 30) begin
      @(negedge i_sys_clk);
      n++;
    end
    `CHK(in_svc, 1'b1)
  endtask

  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    // Random causes while requests are not yet accepted
    repeat (20) cause_op(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    cause_op(8'h00, 8'hFF, 8'h00);
    for (int k = 0; k < 4; k++) bus_op(4'h8 >> k);
    // Vectored service through the acknowledge cycle
    pulse(3'h4);
    @(negedge i_sys_clk) `CHK(link_if.request_acceptance_flag, 1'b1)
    cause_op(8'h10, 8'h00, 8'h10);
    wait_svc();
    `CHK(pc, {10'h000, SLOT, 3'h0})
    `CHK(vec_seen, {2'h3, SLOT, 3'h7})
    `CHK(ack_count, 1)
    `CHK(bad_vec, 1'b0)
    cause_op(8'h00, 8'h10, 8'h10);
    pulse(3'h1);
    pulse(3'h4);
    pulse(3'h2);
    @(negedge i_sys_clk) `CHK(link_if.request_acceptance_flag, 1'b0)
    // Direct host: fixed location, no acknowledge
    @(posedge i_sys_clk) mode <= uhv_pkg::UHV_HOST_DIRECT;
    pulse(3'h4);
    cause_op(8'h01, 8'h00, 8'h01);
    wait_svc();
    `CHK(pc, 16'h0003)
    `CHK(ack_count, 1)
    cause_op(8'h00, 8'h01, 8'h01);
    pulse(3'h1);
    finish_test();
  end

  // Whole run is about 130 cycles; this limit cuts a hang short
  initial begin
    #(3000 * 100);
    fail_count++;
    finish_test();
  end
endmodule

`default_nettype wire
